/* rtl/pin_irq_pkg.sv */
// Shared constants, encodings and helpers for the pin interrupt block
package pin_irq_pkg;

	// Lane counts: 18 external pins plus the non-maskable lane on top
	localparam int PIN_N     = 18;
	localparam int LANE_N    = 19;
	localparam int NMI_LANE  = 18;
	localparam int SENSE_W   = 3;
	localparam int CFG_PINS  = 8;
	localparam int CFG_STEP  = 4;
	localparam int ADDR_W    = 12;

	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_NMI_SENSE   = 8'h02;
	localparam logic [7:0] IDX_NMI_FLAG    = 8'h03;
	localparam logic [7:0] IDX_EVT_OUT_EN  = 8'h04;
	localparam logic [7:0] IDX_IRQ_EN_CLR  = 8'h08;
	localparam logic [7:0] IDX_IRQ_EN_SET  = 8'h0C;
	localparam logic [7:0] IDX_PIN_FLAG    = 8'h10;
	localparam logic [7:0] IDX_PIN_SENSE0  = 8'h18;
	localparam logic [7:0] IDX_PIN_SENSE1  = 8'h19;
	localparam logic [7:0] IDX_PIN_SENSE2  = 8'h1A;

	// Field positions and reset values
	localparam int NMI_FLAG_BIT = 0;
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [17:0] RST_PINS  = 18'h0_0000;
	localparam logic [2:0]  RST_SENSE = 3'h0;

	// Sense selector encoding; codes 6 and 7 never detect
	localparam logic [2:0] SENSE_NONE = 3'h0;
	localparam logic [2:0] SENSE_RISE = 3'h1;
	localparam logic [2:0] SENSE_FALL = 3'h2;
	localparam logic [2:0] SENSE_BOTH = 3'h3;
	localparam logic [2:0] SENSE_HIGH = 3'h4;
	localparam logic [2:0] SENSE_LOW  = 3'h5;

	function automatic logic sense_hit(input logic [2:0] sel,
		input logic cur, input logic prev, input logic armed);
		logic rise;
		logic fall;
		rise = armed & cur & ~prev;
		fall = armed & ~cur & prev;
		case (sel)
			SENSE_RISE: sense_hit = rise;
			SENSE_FALL: sense_hit = fall;
			SENSE_BOTH: sense_hit = rise | fall;
			SENSE_HIGH: sense_hit = cur;
			SENSE_LOW:  sense_hit = ~cur;
			default:    sense_hit = 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] word_index(input logic [11:0] addr);
		word_index = addr[9:2];
	endfunction

endpackage

/* rtl/sense_detect.sv */
// Per-lane edge and level detector driven by the sense selectors
`timescale 1ns/1ps
module sense_detect
	import pin_irq_pkg::*;
(
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        ce,
	input  wire logic [LANE_N-1:0]           lane_in,
	input  wire logic [LANE_N*SENSE_W-1:0]   lane_sense,
	output logic      [LANE_N-1:0]           lane_hit
);
	typedef struct packed
	{
		logic [LANE_N-1:0] prev;
		logic              armed;
	} det_s;

	det_s det_ff;
	det_s nxt_det;

	// Edges need one earlier sample; armed keeps reset from faking one
	always_comb
	begin
		nxt_det = det_ff;
		nxt_det.prev = lane_in;
		nxt_det.armed = 1'b1;
		for (int i = 0; i < LANE_N; i++)
		begin
			lane_hit[i] = sense_hit(lane_sense[i*SENSE_W +: SENSE_W],
				lane_in[i], det_ff.prev[i], det_ff.armed);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			det_ff <= '0;
		else if (ce)
			det_ff <= nxt_det;
	end
endmodule

/* rtl/flag_bank.sv */
// Sticky interrupt flags where a new detection beats a clear
`timescale 1ns/1ps
module flag_bank
	import pin_irq_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic [LANE_N-1:0] flag_set,
	input  wire logic [LANE_N-1:0] flag_clr,
	output logic      [LANE_N-1:0] flag
);
	typedef struct packed
	{
		logic [LANE_N-1:0] flag;
	} bank_s;

	bank_s bank_ff;
	bank_s nxt_bank;

	always_comb
	begin
		nxt_bank = bank_ff;
		nxt_bank.flag = (bank_ff.flag & ~flag_clr) | flag_set;
		flag = bank_ff.flag;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bank_ff <= '0;
		else if (ce)
			bank_ff <= nxt_bank;
	end
endmodule

/* rtl/pin_irq_regs.sv */
// Pin interrupt controller: APB registers, flags, enables and events
//
// Contract
// - Matching NMI pin sets the NMI flag
// - Set NMI flag always requests, never gated
// - Write one clears NMI flag; zero ignored
// - NMI flag bit 0, index 0x03, resets zero
// - Detection emits event when pin enable set
// - Event enables reset zero, write protected
// - Ones written to clear view drop enables
// - Ones written to set view raise enables
// - Both views read enables; reset zero
// - Sense codes: none, rise, fall, both, high, low
// - Pin flag requests only while enabled
`timescale 1ns/1ps
module pin_irq_regs
	import pin_irq_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              write_protect,
	input  wire logic [PIN_N-1:0]  ext_irq_pin_bit,
	input  wire logic              nmi_pin,
	output logic      [PIN_N-1:0]  pin_event_out_en_pulse,
	output logic                   irq,
	output logic                   nmi_req
);
	import pin_irq_pkg::*;

	typedef enum logic {PH_SETUP, PH_DONE} apb_phase_e;

	typedef struct packed
	{
		apb_phase_e              phase;
		logic [31:0]             prdata;
		logic                    pready;
		logic                    pslverr;
		logic [SENSE_W-1:0]      nmi_sense_select;
		logic [PIN_N-1:0]        pin_event_out_en;
		logic [PIN_N-1:0]        irq_en;
		logic [PIN_N*SENSE_W-1:0] pin_sense_select;
		logic [PIN_N-1:0]        pin_event;
		logic                    irq;
		logic                    nmi_req;
	} regs_s;

	regs_s regs_ff;
	regs_s nxt_regs;

	logic [LANE_N-1:0]         lane_hit;
	logic [LANE_N-1:0]         flag;
	logic [LANE_N-1:0]         flag_clr;
	logic [LANE_N*SENSE_W-1:0] lane_sense;
	logic [7:0]                idx;
	logic                      access;
	logic                      finish;
	logic                      mapped;
	logic                      guarded;
	logic                      wr_ok;
	logic [31:0]               rd_val;

	assign lane_sense = {regs_ff.nmi_sense_select, regs_ff.pin_sense_select};

	sense_detect u_detect
	(
		.pclk       (pclk),
		.presetn    (presetn),
		.ce         (ce),
		.lane_in    ({nmi_pin, ext_irq_pin_bit}),
		.lane_sense (lane_sense),
		.lane_hit   (lane_hit)
	);

	flag_bank u_flags
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.flag_set (lane_hit),
		.flag_clr (flag_clr),
		.flag     (flag)
	);

	always_comb
	begin
		int pin;
		pin = 0;
		nxt_regs = regs_ff;
		idx = word_index(paddr);
		access = psel & penable;
		finish = access & (regs_ff.phase == PH_DONE);
		case (idx)
			IDX_NMI_SENSE, IDX_NMI_FLAG, IDX_EVT_OUT_EN, IDX_IRQ_EN_CLR,
			IDX_IRQ_EN_SET, IDX_PIN_FLAG, IDX_PIN_SENSE0, IDX_PIN_SENSE1,
			IDX_PIN_SENSE2: mapped = (paddr[11:10] == 2'h0) &
				(paddr[1:0] == 2'h0);
			default: mapped = 1'b0;
		endcase
		// Status views stay writable when the block is locked
		guarded = (idx != IDX_NMI_FLAG) & (idx != IDX_PIN_FLAG);
		wr_ok = mapped & ~(guarded & write_protect);

		rd_val = RST_WORD;
		case (idx)
			IDX_NMI_SENSE:  rd_val[SENSE_W-1:0] = regs_ff.nmi_sense_select;
			IDX_NMI_FLAG:   rd_val[NMI_FLAG_BIT] = flag[NMI_LANE];
			IDX_EVT_OUT_EN: rd_val[PIN_N-1:0] = regs_ff.pin_event_out_en;
			IDX_IRQ_EN_CLR,
			IDX_IRQ_EN_SET: rd_val[PIN_N-1:0] = regs_ff.irq_en;
			IDX_PIN_FLAG:   rd_val[PIN_N-1:0] = flag[PIN_N-1:0];
			IDX_PIN_SENSE0, IDX_PIN_SENSE1, IDX_PIN_SENSE2:
			begin
				for (int k = 0; k < CFG_PINS; k++)
				begin
					pin = int'(idx - IDX_PIN_SENSE0) * CFG_PINS + k;
					if (pin < PIN_N)
						rd_val[k*CFG_STEP +: SENSE_W] =
							regs_ff.pin_sense_select[pin*SENSE_W +: SENSE_W];
				end
			end
			default: rd_val = RST_WORD;
		endcase
		if (!mapped)
			rd_val = RST_WORD;

		// One wait state so that every bus output comes from a flop
		case (regs_ff.phase)
			PH_SETUP:
			begin
				nxt_regs.pready = 1'b0;
				nxt_regs.pslverr = 1'b0;
				if (access)
				begin
					nxt_regs.phase = PH_DONE;
					nxt_regs.pready = 1'b1;
					nxt_regs.prdata = pwrite ? RST_WORD : rd_val;
					nxt_regs.pslverr = pwrite ? ~wr_ok : ~mapped;
				end
			end
			PH_DONE:
			begin
				nxt_regs.phase = PH_SETUP;
				nxt_regs.pready = 1'b0;
				nxt_regs.pslverr = 1'b0;
			end
			default:
			begin
				nxt_regs.phase = PH_SETUP;
				nxt_regs.pready = 1'b0;
			end
		endcase

		// Reading the pin flags clears only what was returned
		flag_clr = '0;
		if (finish && !pwrite && mapped && idx == IDX_PIN_FLAG)
			flag_clr[PIN_N-1:0] = regs_ff.prdata[PIN_N-1:0];
		if (finish && pwrite && mapped && idx == IDX_NMI_FLAG)
			flag_clr[NMI_LANE] = pwdata[NMI_FLAG_BIT];

		// Writes land on the edge where pready is seen high
		if (finish && pwrite && wr_ok)
		begin
			case (idx)
				IDX_NMI_SENSE:
					nxt_regs.nmi_sense_select = pwdata[SENSE_W-1:0];
				IDX_EVT_OUT_EN:
					nxt_regs.pin_event_out_en = pwdata[PIN_N-1:0];
				IDX_IRQ_EN_CLR:
					nxt_regs.irq_en = regs_ff.irq_en &
						~pwdata[PIN_N-1:0];
				IDX_IRQ_EN_SET:
					nxt_regs.irq_en = regs_ff.irq_en |
						pwdata[PIN_N-1:0];
				IDX_PIN_SENSE0, IDX_PIN_SENSE1, IDX_PIN_SENSE2:
				begin
					for (int k = 0; k < CFG_PINS; k++)
					begin
						pin = int'(idx - IDX_PIN_SENSE0) * CFG_PINS + k;
						if (pin < PIN_N)
							nxt_regs.pin_sense_select[pin*SENSE_W +: SENSE_W] =
								pwdata[k*CFG_STEP +: SENSE_W];
					end
				end
				default: nxt_regs.irq_en = regs_ff.irq_en;
			endcase
		end

		nxt_regs.pin_event = lane_hit[PIN_N-1:0] &
			regs_ff.pin_event_out_en;
		nxt_regs.irq = |(flag[PIN_N-1:0] & regs_ff.irq_en);
		nxt_regs.nmi_req = flag[NMI_LANE];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			regs_ff <= '0;
			regs_ff.phase <= PH_SETUP;
			regs_ff.pin_event_out_en <= RST_PINS;
			regs_ff.irq_en <= RST_PINS;
			regs_ff.nmi_sense_select <= RST_SENSE;
		end
		else if (ce)
			regs_ff <= nxt_regs;
	end

	assign prdata = regs_ff.prdata;
	assign pready = regs_ff.pready;
	assign pslverr = regs_ff.pslverr;
	assign pin_event_out_en_pulse = regs_ff.pin_event;
	assign irq = regs_ff.irq;
	assign nmi_req = regs_ff.nmi_req;
endmodule

/* sim/pin_irq_props.sv */
// Port checks for the pin interrupt block
`timescale 1ns/1ps
module pin_irq_props
(
	input wire logic                            pclk,
	input wire logic                            presetn,
	input wire logic                            psel,
	input wire logic                            penable,
	input wire logic                            pwrite,
	input wire logic [pin_irq_pkg::ADDR_W-1:0]  paddr,
	input wire logic [31:0]                     pwdata,
	input wire logic [31:0]                     prdata,
	input wire logic                            pready,
	input wire logic                            pslverr,
	input wire logic                            write_protect,
	input wire logic                            nmi_pin,
	input wire logic [pin_irq_pkg::PIN_N-1:0]   pin_event_out_en_pulse,
	input wire logic                            irq,
	input wire logic                            nmi_req
);
	import pin_irq_pkg::*;
	logic [2:0]       sns_ff;
	logic [PIN_N-1:0] evt_ff;
	logic [PIN_N-1:0] en_ff;
	wire              done = psel & penable & pready;
	wire              wr = done & pwrite & ~pslverr;
	wire              clr_hit = wr & (paddr == 12'h00C) & pwdata[0];
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Shadow only accepted writes, so a refused write cannot move it
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			{sns_ff, evt_ff, en_ff} <= 39'h00_0000_0000;
		else if (wr)
			case (paddr)
				12'h008: sns_ff <= pwdata[2:0];
				12'h010: evt_ff <= pwdata[17:0];
				12'h020: en_ff <= en_ff & ~pwdata[17:0];
				12'h030: en_ff <= en_ff | pwdata[17:0];
				default: ;
			endcase
	rst_quiet_a: assert property (
		$rose(presetn) |-> !irq && !nmi_req) else $error("active at reset");
	nmi_level_a: assert property (
		sns_ff == SENSE_HIGH && nmi_pin |-> ##2 nmi_req) else $error("nmi lost");
	nmi_clear_a: assert property (
		$fell(nmi_req) |-> $past(clr_hit, 2)) else $error("nmi dropped");
	evt_gate_a: assert property (
		(pin_event_out_en_pulse & ~$past(evt_ff)) == 18'h0_0000)
		else $error("event not gated");
	evt_lock_a: assert property (
		done && pwrite && write_protect && paddr == 12'h010 |-> pslverr)
		else $error("protect ignored");
	en_read_a: assert property (
		done && !pwrite && (paddr == 12'h020 || paddr == 12'h030)
		|-> prdata == {14'h0000, en_ff}) else $error("enable view");
	evt_read_a: assert property (
		done && !pwrite && paddr == 12'h010 |-> prdata == {14'h0000, evt_ff})
		else $error("event enable view");
	irq_gate_a: assert property (
		irq |-> $past(en_ff) != 18'h0_0000) else $error("irq not gated");
	cover property ($rose(nmi_req));
	cover property ($rose(irq));
	cover property (done && pslverr);
endmodule

bind pin_irq_regs pin_irq_props pin_irq_props_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .write_protect(write_protect), .nmi_pin(nmi_pin),
	.pin_event_out_en_pulse(pin_event_out_en_pulse), .irq(irq),
	.nmi_req(nmi_req));

/* sim/pin_stim.sv */
// Pin-side partner: moves the pins only on the clock
`timescale 1ns/1ps
module pin_stim
(
	input  wire logic [17:0] pin_want,
	input  wire logic        nmi_want,
	input  wire logic        pclk,
	output logic      [17:0] ext_irq_pin_bit,
	output logic             nmi_pin
);
	// Pins are synchronous to the block, so change them after the edge
	always @(posedge pclk)
		{ext_irq_pin_bit, nmi_pin} <= {pin_want, nmi_want};
endmodule

/* sim/tb_pin_irq_regs.sv */
// Self-checking bench for the pin interrupt block
`timescale 1ns/1ps
module tb_pin_irq_regs;
	import pin_irq_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        write_protect, nmi_pin, nmi_want, irq, nmi_req, rd_err, ce;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [17:0] pins, pin_want, evt;
	int          err_count, n_compared, cyc, seed, en_m, evt_m, ex;
	pin_irq_regs pin_irq_regs_inst (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .write_protect(write_protect),
		.ext_irq_pin_bit(pins), .nmi_pin(nmi_pin),
		.pin_event_out_en_pulse(evt), .irq(irq), .nmi_req(nmi_req));
	pin_stim pin_stim_inst (.pin_want(pin_want), .nmi_want(nmi_want),
		.pclk(pclk), .ext_irq_pin_bit(pins), .nmi_pin(nmi_pin));
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	function automatic int lfsr(input int s);
		lfsr = s[0] ? (s >> 1) ^ 32'hB400_0000 : s >> 1;
	endfunction
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Waits for pready without assuming a latency; reads are compared
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input string nm, input logic [31:0] exp);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		rd_err = pslverr;
		{psel, penable} <= 2'b00;
		@(posedge pclk);
		if (!w)
			chk(nm, rd, exp);
	endtask
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			test_done;
		end
	end
	initial
	begin
		{presetn, psel, penable, pwrite, write_protect, nmi_want} = 6'h00;
		ce = 1'b1;
		{paddr, pwdata, pin_want} = 62'h0;
		{err_count, n_compared, en_m, evt_m} = '0;
		seed = 80808;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, 12'h00C, 0, "nmi flag", 0);
		apb(0, 12'h010, 0, "event enable", 0);
		apb(0, 12'h030, 0, "enable view", 0);
		write_protect <= 1'b1;
		apb(1, 12'h010, 32'hFFFF_FFFF, "", 0);
		chk("protect error", rd_err, 1);
		write_protect <= 1'b0;
		apb(0, 12'h010, 0, "protected value", 0);
		apb(0, 12'h07C, 0, "unmapped", 0);
		chk("unmapped error", rd_err, 1);
		$display("test reset and protect done");
		for (int c = 0; c < 8; c++)
		begin
			ex = (c >= 1 && c <= 5);
			apb(1, 12'h008, c, "", 0);
			apb(1, 12'h00C, 1, "", 0);
			nmi_want <= 1'b1;
			repeat (3) @(posedge pclk);
			nmi_want <= 1'b0;
			repeat (4) @(posedge pclk);
			chk("nmi request", nmi_req, ex);
			apb(0, 12'h00C, 0, "nmi sense", ex);
			apb(1, 12'h00C, 0, "", 0);
			apb(0, 12'h00C, 0, "nmi write zero", ex);
			apb(1, 12'h00C, 1, "", 0);
			apb(0, 12'h00C, 0, "nmi write one", c == 5);
		end
		$display("test nmi sense done");
		for (int k = 0; k < 3; k++)
			apb(1, 12'(12'h060 + 4 * k), 32'h4444_4444, "", 0);
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			apb(1, 12'h030, seed, "", 0);
			en_m = en_m | (seed & 32'h0003_FFFF);
			apb(0, 12'h030, 0, "set view", en_m);
			seed = lfsr(seed);
			apb(1, 12'h020, seed, "", 0);
			en_m = en_m & ~seed;
			apb(0, 12'h020, 0, "clear view", en_m);
			seed = lfsr(seed);
			evt_m = seed & 32'h0003_FFFF;
			apb(1, 12'h010, seed, "", 0);
			seed = lfsr(seed);
			pin_want <= seed[17:0];
			repeat (4) @(posedge pclk);
			chk("event pulse", evt, seed & evt_m);
			chk("irq", irq, (seed & en_m & 32'h0003_FFFF) != 0);
			pin_want <= 18'h0_0000;
			repeat (4) @(posedge pclk);
			apb(0, 12'h040, 0, "pin flags", seed & 32'h0003_FFFF);
			apb(0, 12'h040, 0, "pin flags cleared", 0);
			chk("irq idle", irq, 0);
		end
		$display("test pin lanes done");
		// A low enable must freeze detection, flags and events alike
		ce <= 1'b0;
		pin_want <= 18'h3_FFFF;
		repeat (4) @(posedge pclk);
		chk("frozen event", evt, 0);
		pin_want <= 18'h0_0000;
		repeat (2) @(posedge pclk);
		ce <= 1'b1;
		@(posedge pclk);
		apb(0, 12'h040, 0, "frozen flags", 0);
		chk("frozen irq", irq, 0);
		$display("test clock enable done");
		test_done;
	end
endmodule
